// >>> inc/flags_map.svh
// bit positions, reset value and apb offsets of the processor_flags block
// included by the design modules and the testbench
`ifndef FLAGS_MAP_SVH
`define FLAGS_MAP_SVH
`define B_CF      5'd0
`define B_PF      5'd2
`define B_AF      5'd4
`define B_ZF      5'd6
`define B_SF      5'd7
`define B_TF      5'd8
`define B_IF      5'd9
`define B_DF      5'd10
`define B_OF      5'd11
`define B_IO_PRIVILEGE_FIELD_LO 5'd12
`define B_NT      5'd14
`define B_RF      5'd16
`define B_VM      5'd17
`define B_AC      5'd18
`define B_VIF     5'd19
`define B_VIP     5'd20
`define B_ID      5'd21
`define FLAGS_RESET    32'h0000_0002
`define FLAGS_WMASK    32'h003F_7FD5
`define STATUS_MASK    32'h0000_08D5
`define SYS_MASK       32'h003F_4300
`define IO_PRIVILEGE_FIELD_MASK      32'h0000_3000
`define OFF_FLAGS      12'h000
`define OFF_CTRL       12'h004
`define OFF_COND       12'h008
`define CTRL_AM        5'd0
`define CTRL_VME       5'd1
`define CTRL_CPL_LO    5'd2
`endif

// >>> inc/flags_pkg.sv
// types shared by the flags block and its flag computation unit
// assumes flags_map.svh on the include path
package flags_pkg;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADC = 4'h1,
    OP_SUB = 4'h2,
    OP_SBB = 4'h3,
    OP_LOG = 4'h4,
    OP_PASS = 4'h5
  } alu_op_type;

  typedef enum logic [3:0] {
    CF_NONE = 4'h0,
    CF_SET  = 4'h1,
    CF_CLR  = 4'h2,
    CF_CMC  = 4'h3,
    CF_BIT  = 4'h4
  } cf_cmd_type;

  typedef struct packed {
    logic       valid;
    alu_op_type op;
    logic [1:0] size;
    logic [31:0] a;
    logic [31:0] b;
  } alu_req_type;

  typedef struct packed {
    logic        cf;
    logic        pf;
    logic        af;
    logic        zf;
    logic        sf;
    logic        of;
    logic [31:0] result;
  } alu_res_type;

  typedef struct packed {
    logic [31:0] flags_r;
    logic [31:0] ctrl_r;
    logic [31:0] prdata_r;
    logic [31:0] result_r;
  } flags_state_type;
endpackage

// >>> hdl/flag_calc.sv
// flag computation for one alu operation, purely combinational
// operand size: 0 byte, 1 word, 2 dword
`timescale 1ns/10ps
`include "flags_map.svh"
module flag_calc
  import flags_pkg::*;
(
  // request
  input  wire alu_req_type req,
  input  wire logic        carry_in,
  // flags out
  output alu_res_type      res
);
  function automatic logic msb_of(input logic [31:0] v, input logic [1:0] s);
    msb_of = (s == 2'h0) ? v[7] : (s == 2'h1) ? v[15] : v[31];
  endfunction

  function automatic logic [31:0] trim(input logic [31:0] v,
                                       input logic [1:0] s);
    trim = (s == 2'h0) ? {24'h000000, v[7:0]} :
           (s == 2'h1) ? {16'h0000, v[15:0]} : v;
  endfunction

  logic [32:0] sum;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] r;
  logic        sub;
  logic        cin;
  logic        cout;

  always_comb
  begin
    a    = trim(req.a, req.size);
    b    = trim(req.b, req.size);
    sub  = (req.op == OP_SUB) || (req.op == OP_SBB);
    cin  = ((req.op == OP_ADC) || (req.op == OP_SBB)) & carry_in;
    if (sub)
      sum = {1'b0, a} - {1'b0, b} - {32'h0, cin};
    else if (req.op == OP_LOG || req.op == OP_PASS)
      sum = {1'b0, a};
    else
      sum = {1'b0, a} + {1'b0, b} + {32'h0, cin};
    r    = trim(sum[31:0], req.size);
    // carry/borrow out of the operand msb
    cout = (req.size == 2'h0) ? (a[8] ^ b[8] ^ sum[8]) :
           (req.size == 2'h1) ? (a[16] ^ b[16] ^ sum[16]) : sum[32];
    res.result = r;
    res.cf = (req.op == OP_LOG || req.op == OP_PASS) ? 1'b0 : cout;
    res.pf = ~^r[7:0];
    res.af = (req.op == OP_LOG || req.op == OP_PASS) ? 1'b0 :
             (a[4] ^ b[4] ^ r[4]);
    res.zf = (r == 32'h0);
    res.sf = msb_of(r, req.size);
    res.of = (req.op == OP_LOG || req.op == OP_PASS) ? 1'b0 :
             (sub ? (msb_of(a, req.size) ^ msb_of(b, req.size)) &
                    (msb_of(a, req.size) ^ msb_of(r, req.size))
                  : ~(msb_of(a, req.size) ^ msb_of(b, req.size)) &
                    (msb_of(a, req.size) ^ msb_of(r, req.size)));
  end
endmodule

// >>> hdl/status_control_flags.sv
// processor_flags register with status flag update and system flag control
// assumes one core clock; apb master in the same domain
//
// Operation
// - carry flag from msb carry or borrow
// - parity flag set for even low-byte ones
// - adjust flag from bit 3 carry
// - zero flag set on zero result
// - sign flag copies result msb
// - overflow flag on signed range overflow
// - of the status flags, only carry flag written directly
// - bit tests copy selected bit into carry
// - adc and sbb use current carry
// - status flags exported as condition codes
// - direction flag selects decrement or increment
// - interrupt enable gates maskable interrupts
// - trap flag enables single step
// - io access allowed when privilege within field
// - io field written only by pop/interrupt_return_instr at 0
// - task link flag tracks nested task
// - resume flag held as control output
// - virtual real mode enable flag
// - alignment check needs mask control too
// - pending flag software-written, used with vme
// - query support flag toggles freely
// - reset and init load 0x00000002
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "flags_map.svh"
module status_control_flags
  import flags_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        init,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // alu request from execution
  input  wire alu_req_type alu_req,
  output logic [31:0]      alu_result,
  // direct carry commands and bit tests
  input  wire cf_cmd_type  cf_cmd,
  input  wire logic        bit_value,
  // direction commands
  input  wire logic        dir_set,
  input  wire logic        dir_clr,
  // flags image load from pop or interrupt_return_instr
  input  wire logic        flags_load,
  input  wire logic        load_is_privileged,
  input  wire logic [31:0] flags_load_data,
  // task link hardware updates
  input  wire logic        task_link_set,
  input  wire logic        task_link_clr,
  // flag outputs to decode and control
  output logic [31:0]      flags_out,
  output logic             irq_allowed,
  output logic             step_enable,
  output logic             string_decrement,
  output logic             io_access_ok,
  output logic             align_check_en,
  output logic             virtual_real_mode,
  output logic             debug_resume,
  output logic             virt_irq_active
);
  flags_state_type st_r;
  flags_state_type st_nxt;
  alu_res_type     res;
  logic [31:0]     f;
  logic [31:0]     wmask;
  logic [1:0]      current_privilege;
  logic            apb_wr;
  logic            apb_rd;
  logic            mapped;

  flag_calc u_calc
  (
    .req      (alu_req),
    .carry_in (st_r.flags_r[`B_CF]),
    .res      (res)
  );

  assign current_privilege    = st_r.ctrl_r[`CTRL_CPL_LO +: 2];
  assign mapped = (paddr == `OFF_FLAGS) || (paddr == `OFF_CTRL) ||
                  (paddr == `OFF_COND);
  assign apb_wr = psel & penable & pwrite & clk_en;
  assign apb_rd = psel & ~penable & ~pwrite;
  // zero-wait answer; stalled while the clock enable is low
  assign pready  = clk_en;
  assign pslverr = psel & penable & ~mapped;

  always_comb
  begin
    st_nxt = st_r;
    f      = st_r.flags_r;
    // execution results define all six status flags
    if (alu_req.valid)
    begin
      f[`B_CF] = res.cf;
      f[`B_PF] = res.pf;
      f[`B_AF] = res.af;
      f[`B_ZF] = res.zf;
      f[`B_SF] = res.sf;
      f[`B_OF] = res.of;
      st_nxt.result_r = res.result;
    end
    // of the status flags, only the carry takes direct commands
    unique case (cf_cmd)
      CF_SET:  f[`B_CF] = 1'b1;
      CF_CLR:  f[`B_CF] = 1'b0;
      CF_CMC:  f[`B_CF] = ~st_r.flags_r[`B_CF];
      CF_BIT:  f[`B_CF] = bit_value;
      default: f[`B_CF] = f[`B_CF];
    endcase
    if (dir_set)
      f[`B_DF] = 1'b1;
    else if (dir_clr)
      f[`B_DF] = 1'b0;
    if (task_link_set)
      f[`B_NT] = 1'b1;
    else if (task_link_clr)
      f[`B_NT] = 1'b0;
    // image load: io field changes only for a privileged pop/interrupt_return_instr at 0
    if (flags_load)
    begin
      wmask = `FLAGS_WMASK;
      if (!(load_is_privileged && current_privilege == 2'h0))
        wmask = wmask & ~`IO_PRIVILEGE_FIELD_MASK;
      f = (f & ~wmask) | (flags_load_data & wmask);
    end
    else
      wmask = 32'h0;
    // software write of system flags; status flags not writable here
    if (apb_wr && paddr == `OFF_FLAGS)
    // the io field is left alone here: only a privileged image load moves it
      f = (f & ~`SYS_MASK) |
          (pwdata & `SYS_MASK);
    if (apb_wr && paddr == `OFF_CTRL)
      st_nxt.ctrl_r = pwdata & 32'h0000_000F;
    f[1] = 1'b1;
    f = f & (`FLAGS_WMASK | `FLAGS_RESET);
    st_nxt.flags_r = f;
    if (apb_rd)
    begin
      unique case (paddr)
        `OFF_FLAGS: st_nxt.prdata_r = st_r.flags_r;
        `OFF_CTRL:  st_nxt.prdata_r = st_r.ctrl_r;
        `OFF_COND:  st_nxt.prdata_r = st_r.flags_r & `STATUS_MASK;
        default:    st_nxt.prdata_r = 32'h0;
      endcase
    end
    if (init)
    begin
      st_nxt.flags_r = `FLAGS_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r.flags_r  <= `FLAGS_RESET;
      st_r.ctrl_r   <= 32'h0;
      st_r.prdata_r <= 32'h0;
      st_r.result_r <= 32'h0;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign prdata            = st_r.prdata_r;
  assign alu_result        = st_r.result_r;
  assign flags_out         = st_r.flags_r;
  assign irq_allowed       = st_r.flags_r[`B_IF];
  assign step_enable       = st_r.flags_r[`B_TF];
  assign string_decrement  = st_r.flags_r[`B_DF];
  assign io_access_ok      = current_privilege <= st_r.flags_r[`B_IO_PRIVILEGE_FIELD_LO +: 2];
  assign align_check_en    = st_r.flags_r[`B_AC] &
                             st_r.ctrl_r[`CTRL_AM];
  assign virtual_real_mode = st_r.flags_r[`B_VM];
  assign debug_resume      = st_r.flags_r[`B_RF];
  assign virt_irq_active   = st_r.ctrl_r[`CTRL_VME] &
                             st_r.flags_r[`B_VIF] &
                             st_r.flags_r[`B_VIP];

  chk_reset_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && init |=> flags_out == `FLAGS_RESET)
    else $error("init did not load reset flags");
  chk_zero_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && alu_req.valid && !init && !flags_load && res.result == 32'h0
    |=> flags_out[`B_ZF])
    else $error("zero flag not set");
  chk_carry_cmds: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && cf_cmd == CF_CMC && !init && !flags_load
    |=> flags_out[`B_CF] != $past(flags_out[`B_CF]))
    else $error("complement carry failed");
  chk_bit_copy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && cf_cmd == CF_BIT && !init && !flags_load
    |=> flags_out[`B_CF] == $past(bit_value))
    else $error("bit test copy failed");
  chk_io_privilege_field_guard: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !init && !(flags_load && load_is_privileged && current_privilege == 2'h0)
    |=> $stable(flags_out[13:12]))
    else $error("io field changed without privilege");
  chk_align_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    align_check_en |-> flags_out[`B_AC])
    else $error("alignment check without flag");
  chk_dir_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && dir_set && !flags_load && !init
    |=> string_decrement)
    else $error("direction flag not held");
  chk_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && !alu_req.valid && cf_cmd == CF_NONE && !flags_load && !init
    |=> $stable(flags_out[`B_ZF]))
    else $error("zero flag changed without cause");
endmodule

// >>> tb/exec_model.sv
// execution unit model: issues alu requests to the flags block
// assumes calls are made from a process synchronous to sys_clk
`timescale 1ns/10ps
module exec_model
  import flags_pkg::*;
(
  // clock
  input  wire logic   sys_clk,
  // alu request
  output alu_req_type alu_req
);
  initial alu_req = '0;

  // back to back issues keep valid high, so idle must end a burst
  task issue(input alu_op_type op, input logic [1:0] sz,
             input logic [31:0] a, input logic [31:0] b);
    @(posedge sys_clk);
    alu_req <= '{1'b1, op, sz, a, b};
  endtask

  task idle;
    @(posedge sys_clk);
    alu_req.valid <= 1'b0;
  endtask
endmodule

// >>> tb/status_control_flags_tb.sv
// self-checking bench for status_control_flags
// assumes flags_pkg compiled first and flags_map.svh on the include path
`timescale 1ns/10ps
`include "flags_map.svh"
module status_control_flags_tb
  import flags_pkg::*;
;
  logic        sys_clk, rst_b, init, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, flags_out, flags_load_data, st, rd, a, bb;
  logic [31:0] alu_result;
  logic        bit_value, dir_set, dir_clr, flags_load, load_is_privileged;
  logic        task_link_set, task_link_clr, err, seen, e, b;
  logic        irq_allowed, step_enable, string_decrement, io_access_ok;
  logic        align_check_en, virtual_real_mode, debug_resume;
  logic        virt_irq_active;
  logic [1:0]  sz;
  alu_op_type  op;
  cf_cmd_type  cf_cmd;
  alu_req_type alu_req;
  int          failures, cmp_count;
  logic [31:0] exp_q[$];

  status_control_flags i_dut (.sys_clk, .rst_b, .clk_en(1'b1), .init,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .alu_req, .alu_result, .cf_cmd, .bit_value, .dir_set, .dir_clr,
    .flags_load, .load_is_privileged, .flags_load_data, .task_link_set,
    .task_link_clr, .flags_out, .irq_allowed, .step_enable,
    .string_decrement, .io_access_ok, .align_check_en,
    .virtual_real_mode, .debug_resume, .virt_irq_active);
  exec_model i_exec (.sys_clk, .alu_req);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task check(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] calc(alu_op_type o, logic [1:0] z,
                                       logic [31:0] x, logic [31:0] y,
                                       logic cin);
    logic [32:0] s;
    logic [31:0] m, r;
    logic        c, v, h;
    int          w;
    w = 8 << z;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1;
    x = x & m;
    y = y & m;
    {c, v, h} = 3'b000;
    if (o == OP_ADD || o == OP_ADC)
      s = {1'b0, x} + {1'b0, y} + 33'(cin & (o == OP_ADC));
    else if (o == OP_SUB || o == OP_SBB)
      s = {1'b0, x} - {1'b0, y} - 33'(cin & (o == OP_SBB));
    else
      s = {1'b0, x};
    r = s[31:0] & m;
    if (o < OP_LOG)
    begin
      c = s[w];
      h = x[4] ^ y[4] ^ r[4];
      v = ((x[w-1] == y[w-1]) == (o < OP_SUB)) && (r[w-1] != x[w-1]);
    end
    return {20'h0, v, 3'b0, r[w-1], r == 0, 1'b0, h, 1'b0, ~^r[7:0],
            1'b0, c};
  endfunction

  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    #1;
  endtask

  task ld(input logic p, input logic [31:0] d);
    @(posedge sys_clk);
    {flags_load, load_is_privileged, flags_load_data} <= {1'b1, p, d};
    @(posedge sys_clk);
    flags_load <= 1'b0;
    #1;
  endtask

  // order: dir_set, dir_clr, task_link_set, task_link_clr
  task pulse(input logic [3:0] v);
    @(posedge sys_clk);
    {dir_set, dir_clr, task_link_set, task_link_clr} <= v;
    @(posedge sys_clk);
    {dir_set, dir_clr, task_link_set, task_link_clr} <= 4'h0;
    #1;
  endtask

  // result notes are consumed once the flags settle after the edge
  always @(posedge sys_clk) seen <= alu_req.valid;
  always @(negedge sys_clk)
    if (seen === 1'b1)
      check(flags_out & `STATUS_MASK, exp_q.pop_front());

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    tally_and_finish;
  end

  initial
  begin
    void'($urandom(32'hD6CE));
    {rst_b, init, psel, penable, pwrite, paddr, pwdata} = '0;
    {bit_value, dir_set, dir_clr, flags_load, load_is_privileged} = '0;
    {flags_load_data, task_link_set, task_link_clr} = '0;
    cf_cmd = CF_NONE;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 check(flags_out, `FLAGS_RESET);
    apb(1'b1, `OFF_FLAGS, 32'hFFFF_FFFF);
    apb(1'b0, `OFF_FLAGS, 32'h0);
    check(rd, `SYS_MASK | `FLAGS_RESET);
    check({irq_allowed, step_enable, debug_resume, virtual_real_mode}, 4'hF);
    apb(1'b1, `OFF_FLAGS, 32'h0);
    apb(1'b0, `OFF_FLAGS, 32'h0);
    check(rd, `FLAGS_RESET);
    check({irq_allowed, step_enable, debug_resume, virtual_real_mode}, 4'h0);
    apb(1'b1, `OFF_CTRL, 32'h1);
    apb(1'b1, `OFF_FLAGS, 32'h001C_0000);
    check({align_check_en, virt_irq_active}, 2'b10);
    apb(1'b1, `OFF_CTRL, 32'h2);
    check({align_check_en, virt_irq_active}, 2'b01);
    apb(1'b1, `OFF_CTRL, 32'hC);
    ld(1'b1, 32'h3002);
    check({flags_out[13:12], io_access_ok}, 3'b000);
    apb(1'b1, `OFF_CTRL, 32'h0);
    ld(1'b1, 32'h2002);
    ld(1'b0, 32'h0002);
    check({flags_out[13:12], io_access_ok}, 3'b101);
    apb(1'b1, `OFF_CTRL, 32'h8);
    check(io_access_ok, 1'b1);
    apb(1'b1, `OFF_CTRL, 32'hC);
    check(io_access_ok, 1'b0);
    apb(1'b1, `OFF_FLAGS, 32'h0);
    check(flags_out[13:12], 2'h2);
    pulse(4'b0011);
    check(flags_out[14], 1'b1);
    pulse(4'b0001);
    check(flags_out[14], 1'b0);
    pulse(4'b1000);
    check(string_decrement, 1'b1);
    pulse(4'b0100);
    check({string_decrement, flags_out}, 33'h0_0000_2002);
    for (int c = 1; c < 6; c++)
    begin
      b = $urandom_range(1);
      @(posedge sys_clk);
      e = c == 1 || c == 3 && !flags_out[0] || c > 3 && b;
      cf_cmd <= cf_cmd_type'(c > 4 ? 4 : c);
      bit_value <= b;
      @(posedge sys_clk);
      cf_cmd <= CF_NONE;
      #1 check(flags_out[0], e);
    end
    st = flags_out & `STATUS_MASK;
    for (int i = 0; i < 40; i++)
    begin
      op = i < 2 ? alu_op_type'(2 * i) : alu_op_type'($urandom_range(5));
      sz = i < 2 ? 2'd0 : 2'($urandom_range(2));
      a = i == 0 ? 32'hFF : i == 1 ? 32'h80 : $urandom;
      bb = i < 2 ? 32'h1 : $urandom;
      st = calc(op, sz, a, bb, st[0]);
      exp_q.push_back(st);
      i_exec.issue(op, sz, a, bb);
    end
    st = calc(OP_PASS, 2'd2, a, bb, st[0]);
    exp_q.push_back(st);
    i_exec.issue(OP_PASS, 2'd2, a, bb);
    i_exec.idle;
    #1 check(alu_result, a);
    apb(1'b0, `OFF_COND, 32'h0);
    check(rd, st);
    apb(1'b0, 12'hFFC, 32'h0);
    check({err, rd}, 33'h1_0000_0000);
    @(posedge sys_clk);
    init <= 1'b1;
    @(posedge sys_clk);
    init <= 1'b0;
    #1 check(flags_out, `FLAGS_RESET);
    tally_and_finish;
  end
endmodule
